/* i2csp_pkg.sv */
// Constants, field layouts and carrier types of the status/prescaler block
package i2csp_pkg;

  localparam int unsigned ADDR_W = 4;
  localparam int unsigned DATA_W = 32;

  // Register offsets (byte addresses)
  localparam logic [ADDR_W-1:0] OFS_STATUS_CTRL = 4'h0;
  localparam logic [ADDR_W-1:0] OFS_DIV_SELECT  = 4'h4;
  localparam logic [ADDR_W-1:0] OFS_IRQ_GATE    = 4'h8;
  localparam logic [ADDR_W-1:0] OFS_RAW_IRQ     = 4'hC;

  // Status word and control word two bit positions
  localparam int unsigned BIT_ROLE  = 7;
  localparam int unsigned BIT_DIR   = 6;
  localparam int unsigned BIT_BUSY  = 5;
  localparam int unsigned BIT_SREQ  = 4;
  localparam int unsigned BIT_ALOST = 3;
  localparam int unsigned BIT_OWN   = 2;
  localparam int unsigned BIT_BCAST = 1;
  localparam int unsigned BIT_LRB   = 0;
  localparam int unsigned BIT_ENA   = 3;
  localparam int unsigned SWRES_LSB = 0;
  localparam int unsigned SWRES_MSB = 1;

  // Divider field
  localparam int unsigned DIV_LSB   = 0;
  localparam int unsigned DIV_W     = 5;
  localparam int unsigned DIVCNT_W  = 6;
  localparam logic [DIVCNT_W-1:0] DIV_ZERO_CODE_RATIO = 6'h20;

  // Gate and raw flag positions
  localparam int unsigned BIT_GATE  = 0;
  localparam int unsigned BIT_RAW   = 0;

  // Reset values
  localparam logic [DATA_W-1:0] RST_STATUS   = 32'h0000_0010;
  localparam logic [DIV_W-1:0]  RST_DIV      = 5'h00;
  localparam logic              RST_GATE     = 1'b0;

  // Software reset key sequence
  localparam logic [1:0] SWRES_KEY_A = 2'h2;
  localparam logic [1:0] SWRES_KEY_B = 2'h1;

  typedef enum logic {
    SWR_IDLE,
    SWR_ARMED
  } i2csp_swr_state_t;

  // Levels reported by the transfer engine (same clock)
  typedef struct packed {
    logic controller_role;
    logic sending_direction;
    logic bus_occupied;
    logic arbitration_lost;
    logic own_address_hit;
    logic broadcast_call_hit;
    logic final_rx_bit;
  } i2csp_engine_t;

  // Requests to the transfer engine
  typedef struct packed {
    logic controller_role;
    logic sending_direction;
    logic start_req;
    logic stop_req;
    logic bus_enable;
    logic soft_reset;
  } i2csp_ctrl_t;

endpackage : i2csp_pkg

/* i2csp_regs.sv */
// Status word, control word two, divider select and interrupt gate
//
// Functional notes
// - Status word and control word two share one address: read status, write control.
// - Status bit 7 shows controller role: 1 controller, 0 target.
// - Status bit 6 shows direction: 1 transmitting, 0 receiving.
// - Status bit 5 shows bus occupancy: 1 busy, 0 free.
// - Status bit 4 is active-low service request; 1 after reset.
// - Status bit 3 reads 1 when arbitration was lost.
// - Status bit 2 reads 1 on own address match or broadcast call.
// - Status bit 1 reads 1 when a broadcast call was detected.
// - Status bit 0 reads the last received bit on the bus.
// - Five-bit divider field, bits 4 to 0, read-write, sets reference divider.
// - Codes 1..31 divide by value, code 0 divides by 32; resets to 0.
// - Gate bit 0 passes bus interrupt when 1, blocks when 0; resets 0.
// - Raw flag readable regardless of gate; write 1 clears, write 0 ignored.
// - Writing 1 to control bit 4 clears pending request; status bit returns 1.
//
// Added by the designer: strobed register access and the register offsets.
`timescale 1ns/100ps
module i2csp_regs
  import i2csp_pkg::*;
(
  input  wire logic                clk_sys_i,
  input  wire logic                rst_i,
  input  wire logic [ADDR_W-1:0]   reg_addr_i,
  input  wire logic [DATA_W-1:0]   reg_wdata_i,
  input  wire logic                reg_we_i,
  input  wire logic                reg_re_i,
  output logic      [DATA_W-1:0]   reg_rdata_o,
  input  wire i2csp_engine_t       engine_i,
  input  wire logic                service_event_i,
  output i2csp_ctrl_t              ctrl_o,
  output logic                     ref_tick_o,
  output logic                     bus_irq_line_o
);

  typedef struct packed {
    logic [DATA_W-1:0]   rdata;
    logic [DIV_W-1:0]    div_sel;
    logic [DIVCNT_W-1:0] div_cnt;
    logic                tick;
    logic                irq_gate;
    logic                raw_irq_flag;
    logic                sreq_n;
    i2csp_swr_state_t    swr;
    i2csp_ctrl_t         ctrl;
  } i2csp_state_t;

  i2csp_state_t st_q;
  i2csp_state_t st_d;

  logic [7:0]          status_byte;
  logic [DIVCNT_W-1:0] div_ratio;
  logic                wr_ctrl;
  logic                wr_div;
  logic                wr_gate;
  logic                wr_raw;

  always_comb begin
    status_byte            = '0;
    status_byte[BIT_ROLE]  = engine_i.controller_role;
    status_byte[BIT_DIR]   = engine_i.sending_direction;
    status_byte[BIT_BUSY]  = engine_i.bus_occupied;
    status_byte[BIT_SREQ]  = st_q.sreq_n;
    status_byte[BIT_ALOST] = engine_i.arbitration_lost;
    // Broadcast call also counts as an address hit
    status_byte[BIT_OWN]   = engine_i.own_address_hit
                           | engine_i.broadcast_call_hit;
    status_byte[BIT_BCAST] = engine_i.broadcast_call_hit;
    status_byte[BIT_LRB]   = engine_i.final_rx_bit;
  end

  // Code zero stands for the largest ratio
  assign div_ratio = (st_q.div_sel == '0) ? DIV_ZERO_CODE_RATIO
                   : {1'b0, st_q.div_sel};

  assign wr_ctrl = reg_we_i && (reg_addr_i == OFS_STATUS_CTRL);
  assign wr_div  = reg_we_i && (reg_addr_i == OFS_DIV_SELECT);
  assign wr_gate = reg_we_i && (reg_addr_i == OFS_IRQ_GATE);
  assign wr_raw  = reg_we_i && (reg_addr_i == OFS_RAW_IRQ);

  always_comb begin
    st_d = st_q;
    st_d.ctrl.start_req  = 1'b0;
    st_d.ctrl.stop_req   = 1'b0;
    st_d.ctrl.soft_reset = 1'b0;

    // Read data live for one cycle only; unmapped reads return zero
    st_d.rdata = '0;
    if (reg_re_i) begin
      if (reg_addr_i == OFS_STATUS_CTRL) begin
        st_d.rdata[7:0] = status_byte;
      end else if (reg_addr_i == OFS_DIV_SELECT) begin
        st_d.rdata[DIV_LSB +: DIV_W] = st_q.div_sel;
      end else if (reg_addr_i == OFS_IRQ_GATE) begin
        st_d.rdata[BIT_GATE] = st_q.irq_gate;
      end else if (reg_addr_i == OFS_RAW_IRQ) begin
        st_d.rdata[BIT_RAW] = st_q.raw_irq_flag;
      end
    end

    if (wr_div) begin
      st_d.div_sel = reg_wdata_i[DIV_LSB +: DIV_W];
    end
    if (wr_gate) begin
      st_d.irq_gate = reg_wdata_i[BIT_GATE];
    end

    // Set wins over a clear in the same cycle
    if (wr_raw && reg_wdata_i[BIT_RAW]) begin
      st_d.raw_irq_flag = 1'b0;
    end
    if (wr_ctrl && reg_wdata_i[BIT_SREQ]) begin
      st_d.sreq_n = 1'b1;
    end
    if (service_event_i) begin
      st_d.raw_irq_flag = 1'b1;
      st_d.sreq_n       = 1'b0;
    end

    if (wr_ctrl) begin
      st_d.ctrl.controller_role   = reg_wdata_i[BIT_ROLE];
      st_d.ctrl.sending_direction = reg_wdata_i[BIT_DIR];
      st_d.ctrl.start_req         = reg_wdata_i[BIT_BUSY];
      // A stop only makes sense on an occupied bus
      st_d.ctrl.stop_req = !reg_wdata_i[BIT_BUSY]
                         && engine_i.bus_occupied;
      // Disabling mid-transfer is refused to avoid a hung bus
      if (reg_wdata_i[BIT_ENA] || !engine_i.bus_occupied) begin
        st_d.ctrl.bus_enable = reg_wdata_i[BIT_ENA];
      end
    end

    // Two-step key guards against a stray single write
    case (st_q.swr)
      SWR_IDLE: begin
        if (wr_ctrl
            && reg_wdata_i[SWRES_MSB:SWRES_LSB] == SWRES_KEY_A) begin
          st_d.swr = SWR_ARMED;
        end
      end
      SWR_ARMED: begin
        if (wr_ctrl) begin
          if (reg_wdata_i[SWRES_MSB:SWRES_LSB] == SWRES_KEY_B) begin
            st_d.ctrl.soft_reset = 1'b1;
            st_d.swr             = SWR_IDLE;
          end else if (reg_wdata_i[SWRES_MSB:SWRES_LSB] != SWRES_KEY_A) begin
            st_d.swr = SWR_IDLE;
          end
        end
      end
      default: begin
        st_d.swr = SWR_IDLE;
      end
    endcase

    // Reference tick every div_ratio cycles
    st_d.tick = 1'b0;
    if (st_q.div_cnt >= div_ratio - 6'h01) begin
      st_d.div_cnt = '0;
      st_d.tick    = 1'b1;
    end else begin
      st_d.div_cnt = st_q.div_cnt + 6'h01;
    end
    // Restart the divider so a new ratio takes effect cleanly
    if (wr_div) begin
      st_d.div_cnt = '0;
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      st_q              <= '0;
      st_q.div_sel      <= RST_DIV;
      st_q.irq_gate     <= RST_GATE;
      st_q.sreq_n       <= RST_STATUS[BIT_SREQ];
      st_q.swr          <= SWR_IDLE;
    end else begin
      st_q <= st_d;
    end
  end

  assign reg_rdata_o    = st_q.rdata;
  assign ctrl_o         = st_q.ctrl;
  assign ref_tick_o     = st_q.tick;
  assign bus_irq_line_o = st_q.raw_irq_flag & st_q.irq_gate;

  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (rst_i);

  AST_WRITE_NOT_STATUS: assert property (
    reg_we_i && reg_addr_i == OFS_STATUS_CTRL && reg_wdata_i[BIT_BUSY]
    |=> ctrl_o.start_req ##1 !ctrl_o.start_req)
    else $error("control write did not act as control");

  AST_ROLE_BIT: assert property (
    reg_re_i && reg_addr_i == OFS_STATUS_CTRL
    |=> reg_rdata_o[BIT_ROLE] == $past(engine_i.controller_role))
    else $error("role bit mismatch");

  AST_DIR_BIT: assert property (
    reg_re_i && reg_addr_i == OFS_STATUS_CTRL
    |=> reg_rdata_o[BIT_DIR] == $past(engine_i.sending_direction))
    else $error("direction bit mismatch");

  AST_BUSY_BIT: assert property (
    reg_re_i && reg_addr_i == OFS_STATUS_CTRL
    |=> reg_rdata_o[BIT_BUSY] == $past(engine_i.bus_occupied))
    else $error("busy bit mismatch");

  AST_SREQ_SET: assert property (
    service_event_i ##1 (reg_re_i && reg_addr_i == OFS_STATUS_CTRL
                         && !service_event_i
                         && !(wr_ctrl && reg_wdata_i[BIT_SREQ]))
    |=> !reg_rdata_o[BIT_SREQ])
    else $error("pending request not shown as low");

  AST_ALOST_BIT: assert property (
    reg_re_i && reg_addr_i == OFS_STATUS_CTRL && engine_i.arbitration_lost
    |=> reg_rdata_o[BIT_ALOST])
    else $error("arbitration loss not shown");

  AST_OWN_BIT: assert property (
    reg_re_i && reg_addr_i == OFS_STATUS_CTRL
    |=> reg_rdata_o[BIT_OWN] == $past(engine_i.own_address_hit
                                      || engine_i.broadcast_call_hit))
    else $error("address hit bit mismatch");

  AST_BCAST_BIT: assert property (
    reg_re_i && reg_addr_i == OFS_STATUS_CTRL
    |=> reg_rdata_o[BIT_BCAST] == $past(engine_i.broadcast_call_hit))
    else $error("broadcast bit mismatch");

  AST_LRB_BIT: assert property (
    reg_re_i && reg_addr_i == OFS_STATUS_CTRL
    |=> reg_rdata_o[BIT_LRB] == $past(engine_i.final_rx_bit))
    else $error("last bit mismatch");

  AST_DIV_READBACK: assert property (
    wr_div ##1 (reg_re_i && reg_addr_i == OFS_DIV_SELECT && !wr_div)
    |=> reg_rdata_o[DIV_LSB +: DIV_W] == $past(reg_wdata_i[4:0], 2))
    else $error("divider readback mismatch");

  AST_DIV_BY_ONE: assert property (
    st_q.div_sel == 5'h01 && !wr_div ##1 !wr_div
    |-> ref_tick_o)
    else $error("divide by one not ticking every cycle");

  AST_DIV_BY_32: assert property (
    (ref_tick_o && st_q.div_sel == 5'h00 && !wr_div) ##1 (!wr_div [*7])
    |=> !ref_tick_o)
    else $error("code zero ticks too soon");

  AST_GATE_PASS: assert property (
    service_event_i && st_q.irq_gate && !wr_gate |=> bus_irq_line_o)
    else $error("enabled interrupt not passed");

  AST_GATE_BLOCK: assert property (
    !st_q.irq_gate |-> !bus_irq_line_o)
    else $error("disabled interrupt reached output");

  AST_RAW_CLEAR: assert property (
    wr_raw && reg_wdata_i[BIT_RAW] && !service_event_i
    |=> !st_q.raw_irq_flag && !bus_irq_line_o)
    else $error("raw flag not cleared by one");

  AST_SREQ_CLEAR: assert property (
    wr_ctrl && reg_wdata_i[BIT_SREQ] && !service_event_i
    |=> st_q.sreq_n)
    else $error("service request not cleared");

  AST_UPPER_ZERO: assert property (
    reg_re_i |=> reg_rdata_o[DATA_W-1:8] == '0)
    else $error("upper bits not zero");

endmodule : i2csp_regs

/* i2csp_engine_model.sv */
// Behavioural transfer engine standing behind the register block
`timescale 1ns/100ps
module i2csp_engine_model
  import i2csp_pkg::*;
(
  input  wire logic          clk_sys_i,
  input  wire logic          rst_i,
  input  wire i2csp_engine_t set_i,
  input  wire logic          fire_i,
  input  wire i2csp_ctrl_t   ctrl_i,
  output i2csp_engine_t      engine_o,
  output logic               service_event_o
);
  logic occ_q;

  // Bus busy follows start and stop requests, plus any forced level
  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      occ_q           <= 1'b0;
      engine_o        <= '0;
      service_event_o <= 1'b0;
    end else begin
      if (ctrl_i.start_req) occ_q <= 1'b1;
      if (ctrl_i.stop_req) occ_q <= 1'b0;
      engine_o              <= set_i;
      engine_o.bus_occupied <= set_i.bus_occupied | occ_q;
      service_event_o       <= fire_i;
    end
  end
endmodule : i2csp_engine_model

/* i2csp_regs_tb.sv */
// Self-checking bench of the status, divider and interrupt gate registers
`timescale 1ns/100ps
`define CHK(a, b) begin check_count++; if ((a) !== (b)) begin fails++; \
  $display("MISMATCH t=%0t got %h exp %h", $time, a, b); end end
module i2csp_regs_tb
  import i2csp_pkg::*;
;
  logic          clk_sys_i = 1'b0;
  logic          rst_i = 1'b1;
  logic [3:0]    addr = '0;
  logic [31:0]   wdata = '0;
  logic          we = 1'b0;
  logic          re = 1'b0;
  logic [31:0]   rdata;
  i2csp_engine_t eng;
  i2csp_engine_t set = '0;
  logic          fire = 1'b0;
  logic          sev;
  i2csp_ctrl_t   ctrl;
  logic          tick;
  logic          irq;
  int            fails = 0;
  int            check_count = 0;
  logic [31:0]   d;
  int            n;
  // Engine levels beside the status byte they must produce
  localparam logic [14:0] ROWS [8] = '{
    {7'h40, 8'h90}, {7'h20, 8'h50}, {7'h10, 8'h30}, {7'h08, 8'h18},
    {7'h04, 8'h14}, {7'h02, 8'h16}, {7'h01, 8'h11}, {7'h00, 8'h10}};
  localparam logic [4:0] CODES [4] = '{5'h03, 5'h01, 5'h1F, 5'h00};
  localparam int RATIO [4] = '{3, 1, 31, 32};

  initial begin
    forever #2.5 clk_sys_i = ~clk_sys_i;
  end

  i2csp_regs i2csp_regs_i (.clk_sys_i(clk_sys_i), .rst_i(rst_i),
    .reg_addr_i(addr), .reg_wdata_i(wdata), .reg_we_i(we), .reg_re_i(re),
    .reg_rdata_o(rdata), .engine_i(eng), .service_event_i(sev),
    .ctrl_o(ctrl), .ref_tick_o(tick), .bus_irq_line_o(irq));
  i2csp_engine_model i2csp_engine_model_i (.clk_sys_i(clk_sys_i),
    .rst_i(rst_i), .set_i(set), .fire_i(fire), .ctrl_i(ctrl),
    .engine_o(eng), .service_event_o(sev));

  task automatic wr(input logic [3:0] a, input logic [31:0] v);
    @(posedge clk_sys_i);
    addr  <= a;
    wdata <= v;
    we    <= 1'b1;
    @(posedge clk_sys_i);
    we <= 1'b0;
  endtask : wr

  // Read data stand only in the cycle after the strobe edge
  task automatic rd(input logic [3:0] a, output logic [31:0] v);
    @(posedge clk_sys_i);
    addr <= a;
    re   <= 1'b1;
    @(posedge clk_sys_i);
    re <= 1'b0;
    #1;
    v = rdata;
  endtask : rd

  task automatic final_report;
    $display("checks %0d mismatches %0d", check_count, fails);
    if (fails == 0 && check_count > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : final_report

  initial begin
    repeat (20000) @(posedge clk_sys_i);
    fails++;
    final_report();
  end

  initial begin
    repeat (8) @(posedge clk_sys_i);
    rst_i <= 1'b0;
    for (int i = 0; i < 8; i++) begin
      set <= i2csp_engine_t'(ROWS[i][14:8]);
      rd(OFS_STATUS_CTRL, d);
      `CHK(d, {24'h0, ROWS[i][7:0]})
    end
    $display("status table done");
    rd(OFS_DIV_SELECT, d);
    `CHK(d, 32'h0000_0000)
    rd(OFS_IRQ_GATE, d);
    `CHK(d, 32'h0000_0000)
    `CHK(irq, 1'b0)
    $display("reset values done");
    wr(OFS_DIV_SELECT, 32'hFFFF_FFE3);
    rd(OFS_DIV_SELECT, d);
    `CHK(d, 32'h0000_0003)
    for (int i = 0; i < 4; i++) begin
      wr(OFS_DIV_SELECT, {27'h0, CODES[i]});
      n = 0;
      while (tick !== 1'b1 && n < 80) begin
        @(posedge clk_sys_i);
        #1 n++;
      end
      n = 0;
      do begin
        @(posedge clk_sys_i);
        #1 n++;
      end while (tick !== 1'b1 && n < 80);
      `CHK(n, RATIO[i])
    end
    $display("divider done");
    wr(OFS_STATUS_CTRL, 32'h0000_0080);
    rd(OFS_STATUS_CTRL, d);
    `CHK(d, 32'h0000_0010)
    `CHK(ctrl.controller_role, 1'b1)
    wr(OFS_STATUS_CTRL, 32'h0000_0002);
    wr(OFS_STATUS_CTRL, 32'h0000_0001);
    #1;
    `CHK(ctrl.soft_reset, 1'b1)
    wr(OFS_STATUS_CTRL, 32'h0000_0028);
    #1;
    `CHK(ctrl.start_req, 1'b1)
    `CHK(ctrl.bus_enable, 1'b1)
    repeat (2) @(posedge clk_sys_i);
    wr(OFS_STATUS_CTRL, 32'h0000_0000);
    #1;
    `CHK(ctrl.stop_req, 1'b1)
    `CHK(ctrl.bus_enable, 1'b1)
    $display("control done");
    wr(OFS_IRQ_GATE, 32'hFFFF_FFFF);
    rd(OFS_IRQ_GATE, d);
    `CHK(d, 32'h0000_0001)
    @(posedge clk_sys_i);
    fire <= 1'b1;
    @(posedge clk_sys_i);
    fire <= 1'b0;
    repeat (2) @(posedge clk_sys_i);
    #1;
    `CHK(irq, 1'b1)
    rd(OFS_STATUS_CTRL, d);
    `CHK(d, 32'h0000_0000)
    wr(OFS_IRQ_GATE, 32'h0000_0000);
    #1;
    `CHK(irq, 1'b0)
    rd(OFS_RAW_IRQ, d);
    `CHK(d, 32'h0000_0001)
    wr(OFS_IRQ_GATE, 32'h0000_0001);
    wr(OFS_RAW_IRQ, 32'h0000_0000);
    #1;
    `CHK(irq, 1'b1)
    wr(OFS_RAW_IRQ, 32'h0000_0001);
    #1;
    `CHK(irq, 1'b0)
    rd(OFS_STATUS_CTRL, d);
    `CHK(d, 32'h0000_0000)
    wr(OFS_STATUS_CTRL, 32'h0000_0010);
    rd(OFS_STATUS_CTRL, d);
    `CHK(d, 32'h0000_0010)
    $display("interrupt done");
    wr(4'h2, 32'hFFFF_FFFF);
    rd(4'h2, d);
    `CHK(d, 32'h0000_0000)
    rd(OFS_DIV_SELECT, d);
    `CHK(d, 32'h0000_0000)
    $display("unmapped done");
    final_report();
  end
endmodule : i2csp_regs_tb
